// ---- inc/cal_seq_pkg.sv ----
/*
 * constants shared by the calibration mode sequencer: register map, mode codes,
 * field positions, reset values and cycle counts.
 * assumes a 32-bit ahb-lite bus with word-aligned registers.
 */
package cal_seq_pkg;
   // register byte offsets
   localparam logic [7:0] MODE_OFFS = 8'h00;
   localparam logic [7:0] CHAN_OFFS = 8'h04;
   localparam logic [7:0] STAT_OFFS = 8'h08;
   localparam logic [7:0] DATA_OFFS = 8'h0c;
   localparam logic [7:0] ZERO_OFFS = 8'h10;
   localparam logic [7:0] FULL_OFFS = 8'h14;
   localparam logic [7:0] IRQ_OFFS = 8'h18;
   localparam logic [7:0] MASK_OFFS = 8'h1c;
   // mode register layout: bits 7:5 operating mode, 4:2 gain
   localparam int MODE_MSB = 7;
   localparam int MODE_LSB = 5;
   localparam int GAIN_MSB = 4;
   localparam int GAIN_LSB = 2;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [2:0] CHAN_RESET = 3'h4;
   // operating modes
   localparam logic [2:0] MD_NORMAL = 3'h0;
   localparam logic [2:0] MD_SYS_OFFSET = 3'h6;
   localparam logic [2:0] MD_BACKGROUND = 3'h7;
   // timing: one modulator measurement phase, in microseconds
   localparam int PHASE_US = 20;
   localparam int CLK_MHZ = 10;
   localparam int PHASE_CYC = PHASE_US * CLK_MHZ;
   // interrupt bits
   localparam int IRQ_CAL_DONE = 0;
   localparam int IRQ_CONV_DONE = 1;
   localparam int IRQ_BG_UPD = 2;
   localparam int NUM_IRQ = 3;
endpackage

// ---- verilog/cal_phase_timer.sv ----
/*
 * phase timer: counts one measurement phase after a start pulse and
 * pulses done at its end.
 * assumes start is only given while idle.
 */
`timescale 1ns/10ps
`default_nettype none
module cal_phase_timer #(
   parameter int CYCLES = 200
) (
   input wire logic hclk, // clock
   input wire logic hresetn, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic start, // start a phase
   output logic busy, // phase running
   output logic done // one-cycle end pulse
);
   logic [15:0] cnt_q;

   // count down to one, then signal the end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         if (start)
         begin
            cnt_q <= 16'(CYCLES);
            busy <= 1'b1;
         end
         else if (busy)
         begin
            if (cnt_q == 16'h0001)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            cnt_q <= cnt_q - 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verilog/cal_mode_seq.sv ----
/*
 * calibration mode sequencer: system-offset and background calibration of a
 * sigma-delta converter, with an ahb-lite register slave and interrupt.
 * assumes a single ahb-lite master; the modulator holds a sample value on
 * mod_data for whatever input in_sel picks, and it is taken at each phase end.
 * normal mode is left to the conversion path outside this block.
 */
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
// What this block does
// RULE_01 - system-offset calibration runs once on selected channel, then mode clears to zero
// RULE_02 - ready flag high at calibration start, low when fresh result is in data
// RULE_03 - zero-scale point taken at selected gain from the external analog input
// RULE_04 - full-scale point taken at selected gain from internal reference over gain
// RULE_05 - background mode interleaves calibration with conversions, lowering word rate
// RULE_06 - background zero-scale taken at selected gain with inputs shorted internally
// RULE_07 - background calibrations update coefficient registers with no host command
// RULE_08 - host should self-calibrate before background mode; full-scale is not refreshed
// RULE_09 - mode register is zero after reset, selecting normal conversion
// RULE_10 - channel bits pick input pair and coefficient pair; reset picks first differential
// RULE_11 - background mode stays until host writes another mode
`timescale 1ns/10ps
`default_nettype none
module cal_mode_seq #(
   parameter int PHASE = cal_seq_pkg::PHASE_CYC
) (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic hsel, // slave select
   input wire logic [7:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write strobe
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire logic [23:0] mod_data, // modulator sample
   output logic [2:0] in_sel, // 0 ext input, 1 shorted, 2 ref over gain
   output logic [2:0] chan_out, // channel to the mux
   output logic [2:0] gain_out, // gain to the front end
   output logic result_ready_n, // data-ready, low when result fresh
   output logic irq // interrupt level
);
   // one-hot states; S_WAIT gives the cleared mode field a cycle before idle looks again
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_ZERO = 6'b000010,
      S_FULL = 6'b000100,
      S_CONV = 6'b001000,
      S_BGZ = 6'b010000,
      S_WAIT = 6'b100000
   } state_t;

   // sequencer and host-visible registers
   state_t state_q;
   logic [7:0] mode_q;
   logic [2:0] chan_q;
   logic [23:0] data_q;
   // coefficient storage: one zero/full pair per calibration register pair
   logic [23:0] zero_q [3];
   logic [23:0] full_q [3];
   // interrupt status and mask, same bit layout
   logic [2:0] irq_q;
   logic [2:0] mask_q;
   // phase timer handshake
   logic ph_start;
   logic ph_busy;
   logic ph_done;
   // bus data-phase bookkeeping
   logic wr_ph_q;
   logic [7:0] addr_q;
   logic rd_addr; // read address phase accepted this cycle
   // decoded fields and strobes
   logic [1:0] pair;
   logic [2:0] mode;
   logic mode_wr;
   logic chan_wr;
   logic mask_wr;
   logic clr_wr;
   logic [2:0] ev;

   assign mode = mode_q[cal_seq_pkg::MODE_MSB:cal_seq_pkg::MODE_LSB];

   // channel to coefficient pair
   // pseudo-differential and differential codes share pairs; the test code uses pair 2
   always_comb
   begin
      unique case (chan_q) // [RULE_10]
         3'h0, 3'h4: pair = 2'h0;
         3'h1, 3'h5: pair = 2'h1;
         default: pair = 2'h2;
      endcase
   end

   // one timer serves every phase, since phases never overlap
   cal_phase_timer #(.CYCLES(PHASE)) u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .start(ph_start),
      .busy(ph_busy),
      .done(ph_done)
   );

   // zero wait states: the address phase is latched, the data phase follows
   // hsize is not decoded: every register is one whole word
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ph_q <= 1'b0;
         addr_q <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else if (ce)
      begin
         wr_ph_q <= hsel && hready && htrans[1] && hwrite;
         if (hsel && hready && htrans[1])
            addr_q <= haddr;
         hreadyout <= 1'b1;
         hresp <= 1'b0; // okay only: no access is ever refused
      end
   end

   // write strobes act in the data phase, while hwdata stands
   assign mode_wr = wr_ph_q && addr_q == cal_seq_pkg::MODE_OFFS;
   assign chan_wr = wr_ph_q && addr_q == cal_seq_pkg::CHAN_OFFS;
   assign mask_wr = wr_ph_q && addr_q == cal_seq_pkg::MASK_OFFS;
   assign clr_wr = wr_ph_q && addr_q == cal_seq_pkg::IRQ_OFFS;
   assign rd_addr = hsel && hready && htrans[1] && !hwrite;

   // read data registered at the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (ce && rd_addr)
      begin
         unique case (haddr)
            cal_seq_pkg::MODE_OFFS: hrdata <= {24'h000000, mode_q};
            cal_seq_pkg::CHAN_OFFS: hrdata <= {29'h00000000, chan_q};
            cal_seq_pkg::STAT_OFFS: hrdata <= {26'h0000000, state_q};
            cal_seq_pkg::DATA_OFFS: hrdata <= {8'h00, data_q};
            cal_seq_pkg::ZERO_OFFS: hrdata <= {8'h00, zero_q[pair]};
            cal_seq_pkg::FULL_OFFS: hrdata <= {8'h00, full_q[pair]};
            cal_seq_pkg::IRQ_OFFS: hrdata <= {29'h00000000, irq_q};
            cal_seq_pkg::MASK_OFFS: hrdata <= {29'h00000000, mask_q};
            default: hrdata <= 32'h00000000; // unmapped reads zero
         endcase
      end
   end

   // host registers; system-offset calibration clears the mode field itself on completion
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode_q <= cal_seq_pkg::MODE_RESET; // [RULE_09]
         chan_q <= cal_seq_pkg::CHAN_RESET; // [RULE_10]
         mask_q <= 3'h0;
      end
      else if (ce)
      begin
         // a host write in the completion cycle wins, so a new mode is never lost
         if (mode_wr)
            mode_q <= hwdata[7:0]; // [RULE_11]
         else if (state_q == S_FULL && ph_done) // [RULE_01]
            mode_q[cal_seq_pkg::MODE_MSB:cal_seq_pkg::MODE_LSB] <= cal_seq_pkg::MD_NORMAL;
         // channel and mask take the low bits only; upper bits are ignored
         if (chan_wr)
            chan_q <= hwdata[2:0];
         if (mask_wr)
            mask_q <= hwdata[2:0];
      end
   end

   // sequencer: one system-offset pass, or conversions interleaved with zero-scale
   // other mode codes leave it idle; normal conversions are handled outside
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_q <= S_IDLE;
      else if (ce)
      begin
         unique case (state_q)
            S_IDLE:
               if (mode == cal_seq_pkg::MD_SYS_OFFSET)
                  state_q <= S_ZERO; // [RULE_01]
               else if (mode == cal_seq_pkg::MD_BACKGROUND)
                  state_q <= S_CONV; // [RULE_05]
            S_ZERO:
               if (ph_done)
                  state_q <= S_FULL;
            S_FULL:
               if (ph_done)
                  state_q <= S_WAIT; // single step, no repeat [RULE_01]
            S_CONV:
               if (ph_done)
                  state_q <= S_BGZ; // calibrate after every conversion [RULE_05]
            S_BGZ:
               if (ph_done)
                  state_q <= (mode == cal_seq_pkg::MD_BACKGROUND) ? S_CONV : S_WAIT; // [RULE_11]
            S_WAIT:
               state_q <= S_IDLE; // lets the cleared mode settle
         endcase
      end
   end

   // start a phase on entry to each measuring state
   // the done cycle is excluded so a phase cannot restart before the state moves on
   assign ph_start = !ph_busy && !ph_done && (state_q == S_ZERO || state_q == S_FULL
      || state_q == S_CONV || state_q == S_BGZ);

   // front-end steering per phase
   // registered, so it trails the state by one cycle, well inside the phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_sel <= 3'h0;
         chan_out <= cal_seq_pkg::CHAN_RESET;
         gain_out <= 3'h0;
      end
      else if (ce)
      begin
         chan_out <= chan_q;
         gain_out <= mode_q[cal_seq_pkg::GAIN_MSB:cal_seq_pkg::GAIN_LSB]; // [RULE_03] [RULE_04]
         unique case (state_q)
            S_ZERO: in_sel <= 3'h0; // external input, held steady by user [RULE_03]
            S_FULL: in_sel <= 3'h2; // internal reference over gain [RULE_04]
            S_BGZ: in_sel <= 3'h1; // inputs shorted [RULE_06]
            default: in_sel <= 3'h0;
         endcase
      end
   end

   // coefficient and data capture; background never touches full-scale
   // conversion words are corrected by the zero coefficient of their own pair
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         data_q <= 24'h000000;
         for (int i = 0; i < 3; i++)
         begin
            zero_q[i] <= 24'h000000;
            full_q[i] <= 24'h000000;
         end
      end
      else if (ce && ph_done)
      begin
         unique case (state_q)
            S_ZERO: zero_q[pair] <= mod_data; // [RULE_03]
            S_FULL:
            begin
               full_q[pair] <= mod_data; // [RULE_04]
               data_q <= mod_data;
            end
            S_CONV: data_q <= mod_data - zero_q[pair];
            S_BGZ: zero_q[pair] <= mod_data; // automatic update [RULE_07] [RULE_08]
            default: data_q <= data_q;
         endcase
      end
   end

   // ready flag: high from system-offset calibration start until a fresh word is stored
   // a word that nobody reads stays flagged until the next system-offset calibration starts
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         result_ready_n <= 1'b1;
      else if (ce)
      begin
         if (state_q == S_IDLE && mode == cal_seq_pkg::MD_SYS_OFFSET)
            result_ready_n <= 1'b1; // [RULE_02]
         else if (ph_done && (state_q == S_FULL || state_q == S_CONV))
            result_ready_n <= 1'b0; // [RULE_02]
         else if (rd_addr && haddr == cal_seq_pkg::DATA_OFFS)
            result_ready_n <= 1'b1; // data read consumes the word
      end
   end

   // one-cycle events, each the end of a measuring phase
   assign ev[cal_seq_pkg::IRQ_CAL_DONE] = ph_done && state_q == S_FULL;
   assign ev[cal_seq_pkg::IRQ_CONV_DONE] = ph_done && state_q == S_CONV;
   assign ev[cal_seq_pkg::IRQ_BG_UPD] = ph_done && state_q == S_BGZ;

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_q <= 3'h0;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         irq_q <= ev | (irq_q & ~(clr_wr ? hwdata[2:0] : 3'h0));
         // level trails status by one edge; the mask gates only the output
         irq <= |(irq_q & mask_q);
      end
   end
endmodule
`default_nettype wire

// ---- sim/cal_seq_asserts.sv ----
/* port assertions for the calibration sequencer.
   assumes one clock domain and single ahb-lite transfers. */
`timescale 1ns/10ps
`default_nettype none
module cal_seq_asserts #(
   parameter int PHASE = 4
) (
   input wire logic hclk, // clock
   input wire logic hresetn, // reset
   input wire logic hsel, // select
   input wire logic [7:0] haddr, // address
   input wire logic [1:0] htrans, // type
   input wire logic hwrite, // write
   input wire logic [31:0] hwdata, // wdata
   input wire logic hready, // ready
   input wire logic [2:0] in_sel, // input
   input wire logic [2:0] chan_out, // channel
   input wire logic [2:0] gain_out, // gain
   input wire logic result_ready_n, // ready
   input wire logic irq // irq
);
   logic mwr_q, cwr_q;
   logic [2:0] cwd_q, gwd_q;
   logic [7:0] ref_q;
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // mark data phases of mode and channel writes, keep their fields
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         mwr_q <= 1'b0;
         cwr_q <= 1'b0;
         cwd_q <= 3'h0;
         gwd_q <= 3'h0;
      end
      else
      begin
         mwr_q <= hsel && hready && htrans[1] && hwrite && haddr == 8'h00;
         cwr_q <= hsel && hready && htrans[1] && hwrite && haddr == 8'h04;
         cwd_q <= cwr_q ? hwdata[2:0] : cwd_q;
         gwd_q <= mwr_q ? hwdata[4:2] : gwd_q;
      end
   // a counter, since the reference phase can outlast a repetition
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         ref_q <= 8'h00;
      else
         ref_q <= (in_sel == 3'h2) ? ref_q + 8'h01 : 8'h00;
   a_ready_rise: assert property (mwr_q && hwdata[7:5] == 3'h6
      |-> ##[1:3] result_ready_n)
      else $error("ready flag not raised at calibration start");
   a_cal_done: assert property ($past(in_sel) == 3'h2 && in_sel != 3'h2
      |-> ##[0:3] !result_ready_n)
      else $error("no fresh result after calibration");
   a_zero_first: assert property (in_sel == 3'h2 && $past(in_sel) != 3'h2
      |-> $past(in_sel) == 3'h0)
      else $error("reference phase not preceded by input phase");
   a_ref_bound: assert property (ref_q <= PHASE + 2)
      else $error("reference phase too long");
   a_bg_enter: assert property (mwr_q && hwdata[7:5] == 3'h7 |-> ##[1:12] in_sel == 3'h1)
      else $error("no shorted-input phase in background mode");
   a_chan_follow: assert property (cwr_q |-> ##[1:3] chan_out == cwd_q)
      else $error("channel output does not follow write");
   a_gain_follow: assert property (mwr_q |-> ##[1:3] gain_out == gwd_q)
      else $error("gain output does not follow write");
   a_reset_vals: assert property (disable iff (1'b0) !hresetn
      |-> chan_out == 3'h4 && gain_out == 3'h0 && result_ready_n && !irq)
      else $error("wrong outputs in reset");
endmodule
bind cal_mode_seq cal_seq_asserts #(.PHASE(PHASE)) chk_u (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .in_sel, .chan_out, .gain_out, .result_ready_n, .irq);
`default_nettype wire

// ---- sim/mod_model.sv ----
/* modulator stand-in: the sample encodes input, channel and gain.
   assumes the sequencer samples it at phase end. */
`timescale 1ns/10ps
`default_nettype none
module mod_model (
   input wire logic [2:0] in_sel, // input
   input wire logic [2:0] chan_out, // channel
   input wire logic [2:0] gain_out, // gain
   output logic [23:0] mod_data // sample
);
   // steady while the selection holds, as a stable source must be
   assign mod_data = {9'h0, in_sel, 3'h0, chan_out, 3'h0, gain_out};
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
/* bench for the calibration sequencer: bus tasks, scenarios, verdict.
   assumes the sequencer, its checker and the modulator model. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0, ce = 1'b1;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, result_ready_n, irq;
   logic [23:0] mod_data;
   logic [2:0] in_sel, chan_out, gain_out;
   int fail_count = 0, comparisons = 0;
   cal_mode_seq #(.PHASE(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .mod_data(mod_data), .in_sel(in_sel), .chan_out(chan_out), .gain_out(gain_out),
      .result_ready_n(result_ready_n), .irq(irq));
   mod_model mod_u (.in_sel(in_sel), .chan_out(chan_out), .gain_out(gain_out),
      .mod_data(mod_data));
   // 100 ns period
   always #50 hclk = ~hclk;
   task automatic close_out();
      if (fail_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      bus(a, 1'b0, 32'h0, x);
      chk(x & m, e);
   endtask
   // irq lags status by one edge, so let two pass
   task automatic settle();
      repeat (2) @(posedge hclk);
      @(negedge hclk);
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      while (result_ready_n !== 1'b0 && n < 100)
      begin
         @(negedge hclk);
         n++;
      end
   endtask
   function automatic logic [31:0] smp(input logic [2:0] s, c, g);
      return {17'h0, s, 3'h0, c, 3'h0, g};
   endfunction
   task automatic t_reset();
      rchk(cal_seq_pkg::MODE_OFFS, 32'hff, 32'h0);
      rchk(cal_seq_pkg::CHAN_OFFS, 32'h7, 32'h4);
      rchk(8'h40, 32'hffffffff, 32'h0);
      chk(chan_out, 32'h4);
   endtask
   task automatic t_offset();
      wr(cal_seq_pkg::MASK_OFFS, 32'h0);
      wr(cal_seq_pkg::CHAN_OFFS, 32'h5);
      wr(cal_seq_pkg::MODE_OFFS, 32'hcc);
      settle();
      chk(result_ready_n, 32'h1);
      chk({chan_out, gain_out}, 32'h2b);
      wait_rdy();
      chk(result_ready_n, 32'h0);
      rchk(cal_seq_pkg::MODE_OFFS, 32'he0, 32'h0);
      rchk(cal_seq_pkg::ZERO_OFFS, 32'hffffff, smp(3'h0, 3'h5, 3'h3));
      rchk(cal_seq_pkg::FULL_OFFS, 32'hffffff, smp(3'h2, 3'h5, 3'h3));
      chk(irq, 32'h0);
      wr(cal_seq_pkg::MASK_OFFS, 32'h1);
      settle();
      chk(irq, 32'h1);
      wr(cal_seq_pkg::IRQ_OFFS, 32'h1);
      settle();
      chk(irq, 32'h0);
   endtask
   task automatic t_backgr();
      int n;
      logic [31:0] x;
      wr(cal_seq_pkg::MODE_OFFS, 32'he8);
      n = 0;
      x = 32'h0;
      while (x[2] !== 1'b1 && n < 40)
      begin
         bus(cal_seq_pkg::IRQ_OFFS, 1'b0, 32'h0, x);
         n++;
      end
      chk(x[2], 32'h1);
      rchk(cal_seq_pkg::ZERO_OFFS, 32'hffffff, smp(3'h1, 3'h5, 3'h2));
      rchk(cal_seq_pkg::FULL_OFFS, 32'hffffff, smp(3'h2, 3'h5, 3'h3));
      bus(cal_seq_pkg::DATA_OFFS, 1'b0, 32'h0, x);
      wait_rdy();
      chk(result_ready_n, 32'h0);
      repeat (40) @(posedge hclk);
      // freeze for six cycles, longer than one phase: a running sequencer would flip in_sel
      ce <= 1'b0;
      @(negedge hclk);
      x = {29'h0, in_sel};
      repeat (6) @(negedge hclk);
      chk(in_sel, x);
      @(posedge hclk);
      ce <= 1'b1;
      rchk(cal_seq_pkg::MODE_OFFS, 32'he0, 32'he0);
      wr(cal_seq_pkg::MODE_OFFS, 32'h0);
   endtask
   initial
   begin
      hresetn <= 1'b0; // a real falling edge, so the async reset acts at once
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_offset();
      t_backgr();
      close_out();
   end
   // cut a hang short
   initial
   begin
      #500000;
      fail_count++;
      close_out();
   end
endmodule
`default_nettype wire
